/* File: core/svrw_pkg.sv */
// Constants for the supervisor reset and watchdog block
package svrw_pkg;
    // Special function register addresses
    localparam logic [7:0] SVRW_PWR_CTRL_ADDR = 8'h87;
    localparam logic [7:0] SVRW_RELOAD_ADDR = 8'hA6;
    localparam logic [7:0] SVRW_KEY_ADDR = 8'hAE;
    // Field positions and values
    localparam int SVRW_LSR_OFF_BIT = 5;
    localparam int SVRW_RELOAD_MSB = 6;
    localparam logic [7:0] SVRW_RELOAD_MAX = 8'h7E;
    localparam logic [7:0] SVRW_KEY_DISABLE = 8'h55;
    localparam logic [7:0] SVRW_KEY_RESET = 8'h00;
    localparam logic [7:0] SVRW_PWR_CTRL_RESET = 8'h00;
    // Watchdog geometry
    localparam int SVRW_WDT_WIDTH = 22;
    localparam int SVRW_RELOAD_WIDTH = 7;
    localparam logic [21:0] SVRW_WDT_TERMINAL = 22'h3FFFFF;
    // Timing
    localparam int SVRW_OSC_PER_MC = 12;
    localparam int SVRW_CLK_MHZ = 250;
    localparam int SVRW_LSR_HOLD_MS = 10;
    localparam int SVRW_LSR_HOLD_CYCLES = SVRW_LSR_HOLD_MS * SVRW_CLK_MHZ * 1000;
    localparam int SVRW_WDT_PULSE_EXP = 15;
    localparam int SVRW_WDT_PULSE_CYCLES = SVRW_OSC_PER_MC * (2 ** SVRW_WDT_PULSE_EXP);
    localparam int SVRW_STRETCH_WIDTH = 22;
endpackage : svrw_pkg

/* File: core/svrw_stretch.sv */
// Pulse stretcher: holds its output for a count of cycles after the trigger falls
`timescale 1ns/10ps
module svrw_stretch #(
    parameter int WIDTH = 22,
    parameter int HOLD_CYCLES = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Trigger and stretched level
    input wire logic trigger_i,
    output logic active_o
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic active_nxt;

    generate
        if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (2 ** WIDTH)) begin : g_bad_hold
            $error("svrw_stretch: hold count does not fit");
        end
    endgenerate

    always_comb begin
        count_nxt = count_r;
        if (trigger_i) begin
            count_nxt = WIDTH'(HOLD_CYCLES);
        end else if (count_r != '0) begin
            count_nxt = count_r - 1'b1;
        end
        active_nxt = trigger_i || (count_r > WIDTH'(1));
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_r <= '0;
            active_o <= 1'b0;
        end else begin
            count_r <= count_nxt;
            active_o <= active_nxt;
        end
    end
endmodule : svrw_stretch

/* File: core/svrw_top.sv */
// Supervisor reset combiner with machine-cycle watchdog
//
// What this block does
// [R1] Any reset source (pin, low supply, watchdog) asserts one internal reset.
// [R2] The internal reset goes to the companion module as active low.
// [R3] At power-up the pin must be held low at least 1 ms.
// [R4] Low-supply reset stays asserted 10 ms after the low condition ends.
// [R5] Low-supply reset enabled by default; software may disable it later.
// [R6] Power control bit 5 at address 87, high disables low-supply reset.
// [R7] Low-supply reset keeps working in idle and power-down.
// [R8] Watchdog is a 22-bit counter, plus one per machine cycle when enabled.
// [R9] A machine cycle is twelve oscillator periods.
// [R10] Watchdog overflow past the terminal count generates internal reset.
// [R11] Reload write 00..7E loads the seven top counter bits, rest cleared.
// [R12] Reload bit 7 is reserved; only bits 6..0 are used.
// [R13] Only key 55 disables the watchdog; any other value keeps it on.
// [R14] Watchdog runs with no software enabling action.
// [R15] Watchdog is enabled after power-up and every reset.
// [R16] Watchdog and reset logic keep running in idle.
// [R17] Idle software should wake periodically to service the watchdog.
// [R18] Timeout is 12 x 2^22 oscillator periods; reset pulse 12 x 2^15 (the code holds reset 12 x 2^15 - 1 cycles).
// [R19] Internal reset clears the counter and returns the key to 00.
`timescale 1ns/10ps
module svrw_top
    import svrw_pkg::*;
#(
    parameter int LSR_HOLD_CYCLES = svrw_pkg::SVRW_LSR_HOLD_CYCLES,
    parameter int WDT_PULSE_CYCLES = svrw_pkg::SVRW_WDT_PULSE_CYCLES
) (
    // Clock and power-on reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Reset sources
    input wire logic ext_reset_n_i,
    input wire logic low_supply_i,
    // Low-power state of the core
    input wire logic idle_i,
    input wire logic power_down_i,
    // Special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_we_i,
    input wire logic sfr_re_i,
    output logic [7:0] sfr_rdata_o,
    // Reset outputs
    output logic core_reset_o,
    output logic companion_reset_n_o,
    output logic guard_overflow_o
);
    import svrw_pkg::*;

    generate
        // Pulse stretcher is loaded with one less than the pulse length
        if (LSR_HOLD_CYCLES < 1 || WDT_PULSE_CYCLES < 2) begin : g_bad_count
            $error("svrw_top: stretch counts too small");
        end
    endgenerate

    function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        sfr_hit = (addr == reg_addr);
    endfunction : sfr_hit

    // Register state
    logic [SVRW_WDT_WIDTH-1:0] guard_count_r;
    logic [SVRW_WDT_WIDTH-1:0] guard_count_nxt;
    logic [3:0] mc_div_r;
    logic [3:0] mc_div_nxt;
    logic [7:0] guard_disable_key_r;
    logic [7:0] guard_disable_key_nxt;
    logic low_supply_reset_off_r;
    logic low_supply_reset_off_nxt;
    logic [7:0] rdata_nxt;
    logic internal_reset_nxt;
    logic overflow_nxt;
    logic mc_tick;
    logic guard_enabled;
    logic lsr_active;
    logic wdt_reset_active;

    // Low-supply detection, stretched by the hold time after the condition clears
    svrw_stretch #(
        .WIDTH(SVRW_STRETCH_WIDTH),
        .HOLD_CYCLES(LSR_HOLD_CYCLES)
    ) u_lsr_stretch (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .trigger_i(low_supply_i && !low_supply_reset_off_r), // [R4] [R5] [R6] [R7]
        .active_o(lsr_active)
    );

    // Watchdog reset pulse, fixed length after overflow
    svrw_stretch #(
        .WIDTH(SVRW_STRETCH_WIDTH),
        .HOLD_CYCLES(WDT_PULSE_CYCLES - 1)
    ) u_wdt_stretch (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .trigger_i(guard_overflow_o), // [R18]
        .active_o(wdt_reset_active)
    );

    // Machine-cycle prescaler; oscillator is taken as stopped in power-down
    always_comb begin
        mc_div_nxt = mc_div_r;
        mc_tick = 1'b0;
        if (core_reset_o) begin
            mc_div_nxt = '0;
        end else if (!power_down_i) begin
            if (mc_div_r == 4'(SVRW_OSC_PER_MC - 1)) begin // [R9]
                mc_div_nxt = '0;
                mc_tick = 1'b1;
            end else begin
                mc_div_nxt = mc_div_r + 4'h1;
            end
        end
    end

    // Enabled unless the key matches; idle does not stop it
    assign guard_enabled = (guard_disable_key_r != SVRW_KEY_DISABLE); // [R13] [R14] [R16]

    always_comb begin
        guard_count_nxt = guard_count_r;
        overflow_nxt = 1'b0;
        guard_disable_key_nxt = guard_disable_key_r;
        low_supply_reset_off_nxt = low_supply_reset_off_r;
        if (core_reset_o) begin
            guard_count_nxt = '0; // [R19]
            guard_disable_key_nxt = SVRW_KEY_RESET; // [R15] [R19]
            low_supply_reset_off_nxt = SVRW_PWR_CTRL_RESET[SVRW_LSR_OFF_BIT]; // [R5]
        end else begin
            if (sfr_we_i && sfr_hit(sfr_addr_i, SVRW_KEY_ADDR)) begin
                guard_disable_key_nxt = sfr_wdata_i; // [R13]
            end
            if (sfr_we_i && sfr_hit(sfr_addr_i, SVRW_PWR_CTRL_ADDR)) begin
                low_supply_reset_off_nxt = sfr_wdata_i[SVRW_LSR_OFF_BIT]; // [R6]
            end
            // Service write beats a same-cycle increment
            if (sfr_we_i && sfr_hit(sfr_addr_i, SVRW_RELOAD_ADDR)
                && ({1'b0, sfr_wdata_i[SVRW_RELOAD_MSB:0]} <= SVRW_RELOAD_MAX)) begin
                guard_count_nxt = {sfr_wdata_i[SVRW_RELOAD_MSB:0], 15'h0000}; // [R11] [R12]
            end else if (guard_enabled && mc_tick) begin
                if (guard_count_r == SVRW_WDT_TERMINAL) begin
                    guard_count_nxt = '0;
                    overflow_nxt = 1'b1; // [R10] [R18]
                end else begin
                    guard_count_nxt = guard_count_r + 22'h000001; // [R8]
                end
            end
        end
    end

    // Combined reset; the pin is taken as already synchronous
    assign internal_reset_nxt = !ext_reset_n_i || lsr_active || wdt_reset_active; // [R1]

    always_comb begin
        rdata_nxt = sfr_rdata_o;
        if (sfr_re_i) begin
            rdata_nxt = 8'h00;
            if (sfr_hit(sfr_addr_i, SVRW_KEY_ADDR)) begin
                rdata_nxt = guard_disable_key_r;
            end else if (sfr_hit(sfr_addr_i, SVRW_PWR_CTRL_ADDR)) begin
                rdata_nxt[SVRW_LSR_OFF_BIT] = low_supply_reset_off_r;
            end else if (sfr_hit(sfr_addr_i, SVRW_RELOAD_ADDR)) begin
                // Top bits of the live count, reserved bit reads zero
                rdata_nxt = {1'b0, guard_count_r[SVRW_WDT_WIDTH-1 -: SVRW_RELOAD_WIDTH]};
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            guard_count_r <= '0;
            mc_div_r <= '0;
            guard_disable_key_r <= SVRW_KEY_RESET;
            low_supply_reset_off_r <= SVRW_PWR_CTRL_RESET[SVRW_LSR_OFF_BIT];
            sfr_rdata_o <= 8'h00;
            core_reset_o <= 1'b1;
            companion_reset_n_o <= 1'b0;
            guard_overflow_o <= 1'b0;
        end else begin
            guard_count_r <= guard_count_nxt;
            mc_div_r <= mc_div_nxt;
            guard_disable_key_r <= guard_disable_key_nxt;
            low_supply_reset_off_r <= low_supply_reset_off_nxt;
            sfr_rdata_o <= rdata_nxt;
            core_reset_o <= internal_reset_nxt; // [R1]
            companion_reset_n_o <= !internal_reset_nxt; // [R2]
            guard_overflow_o <= overflow_nxt;
        end
    end

    // Idle only halts the core; nothing here depends on it
    logic idle_unused;
    assign idle_unused = idle_i;
endmodule : svrw_top

/* File: testbench/svrw_top_assertions.sv */
// Port checker for the supervisor reset and watchdog block
`timescale 1ns/10ps
module svrw_top_checker
    import svrw_pkg::*;
#(
    parameter int LSR_HOLD_CYCLES = 20,
    parameter int WDT_PULSE_CYCLES = 16
) (
    // Clock, reset and sources
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ext_reset_n_i,
    input wire logic low_supply_i,
    // Register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_we_i,
    input wire logic sfr_re_i,
    input wire logic [7:0] sfr_rdata_o,
    // Reset outputs
    input wire logic core_reset_o,
    input wire logic companion_reset_n_o,
    input wire logic guard_overflow_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Mirror of the disable bit; writes are dropped while reset is high
    logic lsr_off_r;
    logic lsr_off_nxt;
    always_comb begin
        lsr_off_nxt = lsr_off_r;
        if (core_reset_o)
            lsr_off_nxt = 1'b0;
        else if (sfr_we_i && sfr_addr_i == SVRW_PWR_CTRL_ADDR)
            lsr_off_nxt = sfr_wdata_i[SVRW_LSR_OFF_BIT];
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            lsr_off_r <= 1'b0;
        else
            lsr_off_r <= lsr_off_nxt;
    end
    AST_COMP: assert property (companion_reset_n_o == !core_reset_o)
        else $error("companion reset not inverse");
    AST_PIN: assert property (!ext_reset_n_i |=> core_reset_o)
        else $error("pin reset missed");
    // Overflow pulse passes the stretcher register before reaching the reset flop
    AST_OVF_RST: assert property (guard_overflow_o |=> ##1 core_reset_o [*8])
        else $error("overflow reset too short");
    AST_OVF_PULSE: assert property (guard_overflow_o |=> !guard_overflow_o)
        else $error("overflow pulse too long");
    AST_LSR_RISE: assert property ((low_supply_i && !lsr_off_r) ##1 low_supply_i |=> core_reset_o)
        else $error("low supply reset missed");
    AST_LSR_HOLD: assert property ((low_supply_i && !lsr_off_r) ##1 low_supply_i [*2] ##1 !low_supply_i
        |-> core_reset_o [*8])
        else $error("low supply reset released early");
    AST_RD_PWR: assert property (sfr_re_i && sfr_addr_i == SVRW_PWR_CTRL_ADDR
        |=> sfr_rdata_o == {2'h0, $past(lsr_off_r), 5'h00})
        else $error("power control read wrong");
    AST_RD_RLD: assert property (sfr_re_i && sfr_addr_i == SVRW_RELOAD_ADDR |=> !sfr_rdata_o[7])
        else $error("reload bit 7 not zero");
    cover property (low_supply_i ##1 core_reset_o);
    cover property (!ext_reset_n_i ##1 core_reset_o);
    cover property (sfr_re_i && sfr_addr_i == SVRW_KEY_ADDR);
endmodule : svrw_top_checker
bind svrw_top svrw_top_checker #(.LSR_HOLD_CYCLES(LSR_HOLD_CYCLES), .WDT_PULSE_CYCLES(WDT_PULSE_CYCLES)) u_chk (
    .clock_i, .rst_n_i, .ext_reset_n_i, .low_supply_i, .sfr_addr_i, .sfr_wdata_i, .sfr_we_i, .sfr_re_i,
    .sfr_rdata_o, .core_reset_o, .companion_reset_n_o, .guard_overflow_o);

/* File: testbench/svrw_core_model.sv */
// Processor core model driving the register port
`timescale 1ns/10ps
module svrw_core_model (
    input wire logic clock_i,
    input wire logic [7:0] sfr_rdata_i,
    output logic [7:0] sfr_addr_o = 8'h00,
    output logic [7:0] sfr_wdata_o = 8'h00,
    output logic sfr_we_o = 1'b0,
    output logic sfr_re_o = 1'b0
);
    // Released bus shows inverted values so stale data never looks live
    task automatic drop();
        sfr_addr_o = ~sfr_addr_o;
        sfr_wdata_o = ~sfr_wdata_o;
    endtask : drop
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock_i);
        sfr_addr_o = addr;
        sfr_wdata_o = data;
        sfr_we_o = 1'b1;
        @(negedge clock_i);
        sfr_we_o = 1'b0;
        drop();
    endtask : wr
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock_i);
        sfr_addr_o = addr;
        sfr_re_o = 1'b1;
        @(negedge clock_i);
        sfr_re_o = 1'b0;
        data = sfr_rdata_i;
        drop();
    endtask : rd
endmodule : svrw_core_model

/* File: testbench/tb_supervisor_reset_watchdog.sv */
// Self-checking bench for the supervisor reset and watchdog block
`timescale 1ns/10ps
module tb_supervisor_reset_watchdog;
    import svrw_pkg::*;
    typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} svrw_row_type;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ext_reset_n_i = 1'b1;
    logic low_supply_i = 1'b0;
    logic idle_i = 1'b0;
    logic power_down_i = 1'b0;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, rd_v;
    logic sfr_we_i, sfr_re_i, core_reset_o, companion_reset_n_o, guard_overflow_o;
    int err_total = 0;
    int total_checks = 0;
    int n;
    // Write then read back; 7F on reload must leave the count alone, 9E loads 1E as bit 7 is ignored
    svrw_row_type rows [9] = '{'{8'h87, 8'hFF, 8'h20}, '{8'h87, 8'h00, 8'h00}, '{8'hAE, 8'h55, 8'h55},
        '{8'hAE, 8'hAA, 8'hAA}, '{8'hA6, 8'h1E, 8'h1E}, '{8'hA6, 8'h7F, 8'h1E}, '{8'hA6, 8'h9E, 8'h1E},
        '{8'hA6, 8'h00, 8'h00}, '{8'h12, 8'hFF, 8'h00}};
    svrw_top #(.LSR_HOLD_CYCLES(20), .WDT_PULSE_CYCLES(16)) DUT (.clock_i, .rst_n_i, .ext_reset_n_i,
        .low_supply_i, .idle_i, .power_down_i, .sfr_addr_i, .sfr_wdata_i, .sfr_we_i, .sfr_re_i, .sfr_rdata_o,
        .core_reset_o, .companion_reset_n_o, .guard_overflow_o);
    svrw_core_model u_core (.clock_i, .sfr_rdata_i(sfr_rdata_o), .sfr_addr_o(sfr_addr_i),
        .sfr_wdata_o(sfr_wdata_i), .sfr_we_o(sfr_we_i), .sfr_re_o(sfr_re_i));
    initial forever #2 clock_i = ~clock_i;
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        #40000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(negedge clock_i);
        chk("core_reset", 8'(core_reset_o), 8'h01);
        chk("companion", 8'(companion_reset_n_o), 8'h00);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        chk("core_reset", 8'(core_reset_o), 8'h00);
        u_core.rd(SVRW_PWR_CTRL_ADDR, rd_v);
        chk("pwr", rd_v, 8'h00);
        u_core.rd(SVRW_KEY_ADDR, rd_v);
        chk("key", rd_v, SVRW_KEY_RESET);
        $display("reset test done");
        foreach (rows[i]) begin
            u_core.wr(rows[i].addr, rows[i].data);
            u_core.rd(rows[i].addr, rd_v);
            chk("row", rd_v, rows[i].exp);
        end
        $display("register rows done");
        u_core.wr(SVRW_KEY_ADDR, SVRW_KEY_DISABLE);
        // Pin pulse far shorter than the power-up minimum; only mid-run behaviour is checked
        ext_reset_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        chk("core_reset", 8'(core_reset_o), 8'h01);
        chk("companion", 8'(companion_reset_n_o), 8'h00);
        ext_reset_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        u_core.rd(SVRW_KEY_ADDR, rd_v);
        chk("key", rd_v, SVRW_KEY_RESET);
        $display("pin test done");
        idle_i = 1'b1;
        power_down_i = 1'b1;
        low_supply_i = 1'b1;
        repeat (3) @(negedge clock_i);
        chk("core_reset", 8'(core_reset_o), 8'h01);
        low_supply_i = 1'b0;
        repeat (10) @(negedge clock_i);
        chk("core_reset", 8'(core_reset_o), 8'h01);
        n = 0;
        while (core_reset_o !== 1'b0 && n < 40) begin
            @(negedge clock_i);
            n++;
        end
        chk("hold", 8'(n >= 7 && n <= 14), 8'h01);
        idle_i = 1'b0;
        power_down_i = 1'b0;
        $display("low supply test done");
        u_core.wr(SVRW_PWR_CTRL_ADDR, 8'h20);
        low_supply_i = 1'b1;
        repeat (5) @(negedge clock_i);
        chk("core_reset", 8'(core_reset_o), 8'h00);
        low_supply_i = 1'b0;
        // Full timeout is out of reach here; no spurious overflow may appear
        chk("overflow", 8'(guard_overflow_o), 8'h00);
        $display("supply disable test done");
        tally_and_finish();
    end
endmodule : tb_supervisor_reset_watchdog
